// File: cbe_map.svh
// constants for the conditional branch evaluator
`ifndef CBE_MAP_SVH
`define CBE_MAP_SVH
`define CBE_PC_W       16
`define CBE_K_W        7
`define CBE_FLAG_C     0
`define CBE_FLAG_Z     1
`define CBE_FLAG_N     2
`define CBE_FLAG_V     3
`define CBE_FLAG_S     4
`define CBE_FLAG_H     5
`define CBE_FLAG_T     6
`define CBE_FLAG_I     7
`define CBE_TAKEN_CYC  2
`define CBE_FALL_CYC   1
`endif

// File: cbe_pkg.sv
// types for the conditional branch evaluator
package cbe_pkg;
  typedef enum logic [3:0] {
    cbe_op_none       = 4'h0,
    cbe_op_lower      = 4'h1,
    cbe_op_minus      = 4'h2,
    cbe_op_plus       = 4'h3,
    cbe_op_signed_ge  = 4'h4,
    cbe_op_signed_lt  = 4'h5,
    cbe_op_hc_set     = 4'h6,
    cbe_op_hc_clear   = 4'h7,
    cbe_op_t_set      = 4'h8,
    cbe_op_same_high  = 4'h9
  } cbe_op_e;
  typedef enum logic [0:0] {
    cbe_st_idle = 1'b0,
    cbe_st_jump = 1'b1
  } cbe_state_e;
endpackage

// File: cbe_cond.sv
// condition test of one branch opcode against the status flags
`timescale 1ns/1ps
`include "cbe_map.svh"
module cbe_cond
  import cbe_pkg::*;
(
  input  wire cbe_pkg::cbe_op_e op,
  input  wire logic [7:0]       status_flags,
  output logic                  cond_true
);
  import cbe_pkg::*;

  // flag taps
  wire c_f = status_flags[`CBE_FLAG_C];
  wire n_f = status_flags[`CBE_FLAG_N];
  wire v_f = status_flags[`CBE_FLAG_V];
  wire h_f = status_flags[`CBE_FLAG_H];
  wire t_f = status_flags[`CBE_FLAG_T];
  wire s_f = n_f ^ v_f;  // signed test, n xor v
  // select the tested condition
  always_comb
  begin
    case (op)
      cbe_op_lower:     cond_true = c_f;
      cbe_op_minus:     cond_true = n_f;
      cbe_op_plus:      cond_true = ~n_f;
      cbe_op_signed_ge: cond_true = ~s_f;
      cbe_op_signed_lt: cond_true = s_f;
      cbe_op_hc_set:    cond_true = h_f;
      cbe_op_hc_clear:  cond_true = ~h_f;
      cbe_op_t_set:     cond_true = t_f;
      cbe_op_same_high: cond_true = ~c_f;
      default:          cond_true = 1'b0;
    endcase
  end
endmodule // cbe_cond

// File: cbe_top.sv
// conditional relative branch evaluator of the core
`timescale 1ns/1ps
`include "cbe_map.svh"
//Contract
// - lower branch jumps to pc+k+1 when carry is one
// - minus branch jumps when negative flag is one
// - plus branch jumps when negative flag is zero
// - signed ge branch jumps when n xor v is zero
// - signed lt branch jumps when n xor v is one
// - half carry set branch jumps when h is one
// - half carry clear branch jumps when h is zero
// - transfer set branch jumps when t is one
// - no branch changes any status flag
// - same or higher branch jumps when carry is zero
module cbe_top
  import cbe_pkg::*;
#(
  parameter int PC_W = `CBE_PC_W,
  parameter int K_W  = `CBE_K_W
)
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 issue,
  input  wire cbe_pkg::cbe_op_e     op,
  input  wire logic [K_W-1:0]       offset_k,
  input  wire logic [PC_W-1:0]      pc_in,
  input  wire logic [7:0]           flags_in,
  output logic                      busy,
  output logic                      done,
  output logic                      taken,
  output logic                      pc_we,
  output logic [PC_W-1:0]           pc_out,
  output logic [7:0]                status_flags
);
  import cbe_pkg::*;

  cbe_state_e       state;
  cbe_state_e       next_state;
  logic             cond_true;
  logic [PC_W-1:0]  target;

  // condition decode
  cbe_cond u_cond
  (
    .op           (op),
    .status_flags (flags_in),
    .cond_true    (cond_true)
  );

  // target and fall-through addresses
  wire [PC_W-1:0] k_ext   = PC_W'(signed'(offset_k));
  wire [PC_W-1:0] pc_jump = pc_in + k_ext + PC_W'(1);
  wire [PC_W-1:0] pc_next = pc_in + PC_W'(1);
  wire            accept  = issue && (state == cbe_st_idle);
  wire            jump    = accept && cond_true;
  // instruction completes now: a fall-through or the second taken cycle
  wire            retire  = (accept && !cond_true) || (state == cbe_st_jump);

  // sequencer: taken branches spend a second cycle
  always_comb
  begin
    case (state)
      cbe_st_idle: next_state = jump ? cbe_st_jump : cbe_st_idle;
      cbe_st_jump: next_state = cbe_st_idle;
      default:     next_state = cbe_st_idle;
    endcase
  end

  // state and held target
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state  <= cbe_st_idle;
      target <= '0;
    end
    else
    begin
      state <= next_state;
      if (jump)
        target <= pc_jump;
    end
  end

  // registered outputs toward the core
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy   <= 1'b0;
      done   <= 1'b0;
      taken  <= 1'b0;
      pc_we  <= 1'b0;
      pc_out <= '0;
    end
    else
    begin
      busy  <= jump;
      done  <= retire;
      taken <= (state == cbe_st_jump);
      pc_we <= retire;
      if (state == cbe_st_jump)
        pc_out <= target;
      else if (accept)
        pc_out <= pc_next;
    end
  end

  // flags pass through unchanged
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      status_flags <= 8'h00;
    else
      status_flags <= flags_in;
  end

  // checks
  property p_flags_kept;
    @(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> status_flags == $past(flags_in);
  endproperty
  a_flags_kept: assert property (p_flags_kept)
    else $error("status flags changed by branch");

  property p_fall_one;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && !cond_true |=>
      done && !taken && pc_out == $past(pc_in) + PC_W'(1);
  endproperty
  a_fall_one: assert property (p_fall_one)
    else $error("fall-through not done in one cycle");

  property p_taken_two;
    @(posedge clk_sys) disable iff (!rst_n)
    jump |=> busy && !done ##1 done && taken && pc_out == $past(target);
  endproperty
  a_taken_two: assert property (p_taken_two)
    else $error("taken branch not done in two cycles");

  property p_target;
    @(posedge clk_sys) disable iff (!rst_n)
    jump |=> target == $past(pc_in) + PC_W'(1) +
      {{(PC_W-K_W){$past(offset_k[K_W-1])}}, $past(offset_k)};
  endproperty
  a_target: assert property (p_target)
    else $error("wrong branch target");

  property p_lower;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && op == cbe_op_lower |-> jump == flags_in[`CBE_FLAG_C];
  endproperty
  a_lower: assert property (p_lower)
    else $error("lower branch decision wrong");

  property p_same_high;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && op == cbe_op_same_high |-> jump != flags_in[`CBE_FLAG_C];
  endproperty
  a_same_high: assert property (p_same_high)
    else $error("same or higher decision wrong");

  property p_signed_lt;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && op == cbe_op_signed_lt |->
      jump == (flags_in[`CBE_FLAG_N] ^ flags_in[`CBE_FLAG_V]);
  endproperty
  a_signed_lt: assert property (p_signed_lt)
    else $error("signed less-than decision wrong");

  property p_hc_clear;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && op == cbe_op_hc_clear |-> jump == !flags_in[`CBE_FLAG_H];
  endproperty
  a_hc_clear: assert property (p_hc_clear)
    else $error("half carry clear decision wrong");

  // decision checks worked out from the flag bits, apart from the decoder
  property p_minus;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && op == cbe_op_minus |-> jump == flags_in[`CBE_FLAG_N];
  endproperty
  a_minus: assert property (p_minus)
    else $error("minus branch decision wrong");

  property p_plus;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && op == cbe_op_plus |-> jump == !flags_in[`CBE_FLAG_N];
  endproperty
  a_plus: assert property (p_plus)
    else $error("plus branch decision wrong");

  property p_signed_ge;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && op == cbe_op_signed_ge |->
      jump == !(flags_in[`CBE_FLAG_N] ^ flags_in[`CBE_FLAG_V]);
  endproperty
  a_signed_ge: assert property (p_signed_ge)
    else $error("signed greater-or-equal decision wrong");

  property p_hc_set;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && op == cbe_op_hc_set |-> jump == flags_in[`CBE_FLAG_H];
  endproperty
  a_hc_set: assert property (p_hc_set)
    else $error("half carry set decision wrong");

  property p_t_set;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && op == cbe_op_t_set |-> jump == flags_in[`CBE_FLAG_T];
  endproperty
  a_t_set: assert property (p_t_set)
    else $error("transfer set decision wrong");

  // codes outside the branch set always fall through
  property p_unknown_op;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && (op == cbe_op_none || op > cbe_op_same_high) |-> !jump;
  endproperty
  a_unknown_op: assert property (p_unknown_op)
    else $error("unknown opcode was taken");

  // the second cycle of a taken branch lasts exactly one clock
  property p_busy_one;
    @(posedge clk_sys) disable iff (!rst_n)
    busy |=> !busy && done && taken;
  endproperty
  a_busy_one: assert property (p_busy_one)
    else $error("taken branch second cycle not single");

  c_taken: cover property (@(posedge clk_sys) disable iff (!rst_n) jump);
  c_fall: cover property (@(posedge clk_sys) disable iff (!rst_n)
    accept && !cond_true);
  c_back: cover property (@(posedge clk_sys) disable iff (!rst_n)
    jump && offset_k[K_W-1]);
  c_refused: cover property (@(posedge clk_sys) disable iff (!rst_n)
    busy && issue);
endmodule // cbe_top

// File: cbe_top_test.sv
// self-checking testbench of the conditional branch evaluator
`timescale 1ns/1ps
module cbe_top_test;
  import cbe_pkg::*;
  logic          clk_sys = 1'b0;
  logic          rst_n = 1'b0;
  logic          issue = 1'b0;
  cbe_op_e       op = cbe_op_none;
  logic [6:0]    offset_k = 7'h00;
  logic [15:0]   pc_in = 16'h0000;
  logic [7:0]    flags_in = 8'h00;
  logic          busy, done, taken, pc_we;
  logic [15:0]   pc_out;
  logic [7:0]    status_flags;
  int            n_fail = 0;
  int            n_checks = 0;

  // core clock, 4 ns period
  always #2 clk_sys = ~clk_sys;

  cbe_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .issue(issue), .op(op),
    .offset_k(offset_k), .pc_in(pc_in), .flags_in(flags_in), .busy(busy),
    .done(done), .taken(taken), .pc_we(pc_we), .pc_out(pc_out),
    .status_flags(status_flags));

  // compare one value with its expectation
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // branch condition worked out from the flags
  function automatic logic exp_cond(input cbe_op_e o, input logic [7:0] f);
    case (o)
      cbe_op_lower:     return f[0];
      cbe_op_minus:     return f[2];
      cbe_op_plus:      return !f[2];
      cbe_op_signed_ge: return !(f[2] ^ f[3]);
      cbe_op_signed_lt: return f[2] ^ f[3];
      cbe_op_hc_set:    return f[5];
      cbe_op_hc_clear:  return !f[5];
      cbe_op_t_set:     return f[6];
      cbe_op_same_high: return !f[0];
      default:          return 1'b0;
    endcase
  endfunction

  // issue one branch and judge its completion
  task automatic do_branch(input cbe_op_e o, input logic [7:0] f,
                           input logic [6:0] k, input logic [15:0] pc);
    logic        t;
    logic        b1;
    logic [15:0] exp_pc;
    int          n;
    t = exp_cond(o, f);
    exp_pc = t ? pc + {{9{k[6]}}, k} + 16'h0001 : pc + 16'h0001;
    @(posedge clk_sys);
    issue <= 1'b1;
    op <= o;
    flags_in <= f;
    offset_k <= k;
    pc_in <= pc;
    @(posedge clk_sys);
    issue <= 1'b0;
    #1;
    n = 1;
    b1 = busy;
    while (done !== 1'b1 && n < 4)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (done !== 1'b1)
    begin
      n_fail++;
      report_and_stop();
    end
    check(16'(n), t ? 16'h0002 : 16'h0001);
    check({15'h0, b1}, {15'h0, t});
    check({15'h0, taken}, {15'h0, t});
    check({15'h0, pc_we}, 16'h0001);
    check(pc_out, exp_pc);
    check({8'h00, status_flags}, {8'h00, f});
  endtask

  // every code of op against flag sets that make each branch opcode true and false
  task automatic t_conditions;
    logic [7:0] fs [3] = '{8'h00, 8'hff, 8'h08};
    for (int i = 0; i < 16; i++)
      foreach (fs[j])
        do_branch(cbe_op_e'(i), fs[j], 7'h05, 16'h0100 + 16'(i));
  endtask

  // negative offsets and wrap of the program counter
  task automatic t_backward;
    do_branch(cbe_op_lower, 8'h01, 7'h7f, 16'h0000);
    do_branch(cbe_op_lower, 8'h01, 7'h40, 16'h0010);
    do_branch(cbe_op_same_high, 8'h01, 7'h40, 16'hffff);
  endtask

  // request in the busy cycle after a taken branch is ignored
  task automatic t_refused;
    @(posedge clk_sys);
    issue <= 1'b1;
    op <= cbe_op_minus;
    flags_in <= 8'h04;
    offset_k <= 7'h10;
    pc_in <= 16'h0200;
    @(posedge clk_sys);
    op <= cbe_op_plus;
    pc_in <= 16'h0300;
    @(posedge clk_sys);
    issue <= 1'b0;
    #1;
    check({15'h0, taken}, 16'h0001);
    check({15'h0, done}, 16'h0001);
    check(pc_out, 16'h0211);
    @(posedge clk_sys);
    #1;
    check({15'h0, done}, 16'h0000);
    check(pc_out, 16'h0211);
  endtask

  // reset, scenarios, verdict
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_conditions();
    t_backward();
    t_refused();
    report_and_stop();
  end
endmodule // cbe_top_test
